// ### verilog/sru_pkg.sv
// shared constants and types for the shift and rotate unit
package sru_pkg;
  localparam int unsigned QUARTERS_PER_CYCLE = 4;
  // quarter ticks for the base single cycle and the base pair time
  localparam logic [5:0] SINGLE_BASE_Q = 6'h04;
  localparam logic [5:0] PAIR_BASE_Q = 6'h05;
  localparam logic [5:0] SINGLE_STEP_Q = 6'h01;
  localparam logic [5:0] PAIR_STEP_Q = 6'h02;
  localparam int unsigned PAIR_BIT = 11;
  localparam int unsigned OPC_LSB = 4;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // single codes are instruction bits 10..3, pair codes bits 10..4
  typedef enum logic [7:0] {
    SRU_OP_ACC_LL = 8'h6A,
    SRU_OP_IDX_LR = 8'h75,
    SRU_OP_IDX_LL = 8'h65,
    SRU_OP_ACC_RR = 8'h3A,
    SRU_OP_ACC_RL = 8'h2A,
    SRU_OP_IDX_RL = 8'h25,
    SRU_OP_IDX_RR = 8'h35,
    SRU_OP_ALIGN = 8'h45,
    SRU_OP_SIGN_LINK = 8'h68
  } sru_single_op_t;

  typedef enum logic [6:0] {
    SRU_OP_PAIR_LR = 7'h38,
    SRU_OP_PAIR_LL = 7'h30,
    SRU_OP_PAIR_RR = 7'h18,
    SRU_OP_PAIR_RL = 7'h10
  } sru_pair_op_t;

  typedef struct packed {
    logic link;
    logic [15:0] acc;
    logic [15:0] idx;
  } sru_regs_t;

  typedef enum logic [1:0] {
    SRU_IDLE = 2'b00,
    SRU_RUN = 2'b01,
    SRU_DONE = 2'b10
  } sru_state_t;
endpackage

// ### verilog/sru_shift_unit.sv
// shift and rotate datapath with quarter-cycle stretch timer
`timescale 1ns/1ps
module sru_shift_unit (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [15:0] instr_i,
  input wire sru_pkg::sru_regs_t regs_i,
  input wire logic qtick_i,
  output logic busy_o,
  output logic done_o,
  output sru_pkg::sru_regs_t regs_o
);
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  sru_pkg::sru_state_t state_reg, state_next;
  sru_pkg::sru_regs_t work_reg, work_next;
  logic [15:0] instr_reg;
  logic [4:0] places_reg, places_next;
  logic [5:0] qleft_reg, qleft_next;
  logic busy_reg, done_reg;

  // decode of the captured instruction and of instr_i at start
  // pair select by bit 11
  wire is_pair = instr_reg[sru_pkg::PAIR_BIT];
  wire [7:0] sop = instr_reg[10:3];
  wire [6:0] pop = instr_reg[10:4];
  wire in_pair = instr_i[sru_pkg::PAIR_BIT];
  wire [4:0] in_places = in_pair ? {1'b0, instr_i[3:0]} + 5'h01 : {2'b00, instr_i[2:0]} + 5'h01;
  wire [5:0] in_k = in_pair ? {2'b00, instr_i[3:0]} : {3'b000, instr_i[2:0]};
  wire in_sign = (instr_i[10:3] == sru_pkg::SRU_OP_SIGN_LINK) && !in_pair;
  wire [5:0] single_q = sru_pkg::SINGLE_BASE_Q + in_k * sru_pkg::SINGLE_STEP_Q;
  wire [5:0] pair_q = sru_pkg::PAIR_BASE_Q + in_k * sru_pkg::PAIR_STEP_Q;
  // sign copy finishes in one cycle
  wire [5:0] in_q = in_sign ? sru_pkg::SINGLE_BASE_Q : (in_pair ? pair_q : single_q);

  wire lk = work_reg.link;
  wire [15:0] a = work_reg.acc;
  wire [15:0] x = work_reg.idx;
  wire aligned = x[15] ^ x[14];

  // one place of movement per pass
  sru_pkg::sru_regs_t step;
  logic step_stop;
  always_comb begin
    step = work_reg;
    step_stop = 1'b0;
    if (is_pair) begin
      case (pop)
        sru_pkg::SRU_OP_PAIR_LR: step = {x[0], 1'b0, a[15:1], a[0], x[15:1]};
        sru_pkg::SRU_OP_PAIR_LL: step = {a[15], a[14:0], x[15], x[14:0], 1'b0};
        sru_pkg::SRU_OP_PAIR_RR: step = {x[0], lk, a[15:1], a[0], x[15:1]};
        sru_pkg::SRU_OP_PAIR_RL: step = {a[15], a[14:0], x[15], x[14:0], lk};
        default: step = work_reg;
      endcase
    end else begin
      case (sop)
        sru_pkg::SRU_OP_ACC_LL: step = {a[15], a[14:0], 1'b0, x};
        sru_pkg::SRU_OP_IDX_LR: step = {x[0], a, 1'b0, x[15:1]};
        sru_pkg::SRU_OP_IDX_LL: step = {x[15], a, x[14:0], 1'b0};
        sru_pkg::SRU_OP_ACC_RR: step = {a[0], lk, a[15:1], x};
        sru_pkg::SRU_OP_ACC_RL: step = {a[15], a[14:0], lk, x};
        sru_pkg::SRU_OP_IDX_RL: step = {x[15], a, x[14:0], lk};
        sru_pkg::SRU_OP_IDX_RR: step = {x[0], a, lk, x[15:1]};
        sru_pkg::SRU_OP_ALIGN: begin
          if (aligned) begin
            step = {1'b1, a, x};
            step_stop = 1'b1;
          end else begin
            step = {lk, a, x[15], x[13:0], 1'b0};
          end
        end
        sru_pkg::SRU_OP_SIGN_LINK: step = {a[15], a, x};
        default: step = work_reg;
      endcase
    end
  end

  // last shift may align the result
  wire align_op = !is_pair && (sop == sru_pkg::SRU_OP_ALIGN);
  wire [15:0] step_x = step.idx;
  wire last_aligned = align_op && !step_stop && (step_x[15] ^ step_x[14]);

  always_comb begin
    state_next = state_reg;
    work_next = work_reg;
    places_next = places_reg;
    qleft_next = qleft_reg;
    case (state_reg)
      sru_pkg::SRU_IDLE: begin
        if (start_i) begin
          work_next = regs_i;
          places_next = in_places;
          qleft_next = in_q;
          state_next = sru_pkg::SRU_RUN;
        end
      end
      sru_pkg::SRU_RUN: begin
        if (places_reg != 5'h00) begin
          work_next = step;
          places_next = places_reg - 5'h01;
          if (step_stop) begin
            places_next = 5'h00;
          end else if (last_aligned) begin
            work_next.link = 1'b1;
            places_next = 5'h00;
          end
          if (!is_pair && sop == sru_pkg::SRU_OP_SIGN_LINK) begin
            places_next = 5'h00;
          end
        end
        if (qtick_i && qleft_reg != 6'h00) begin
          qleft_next = qleft_reg - 6'h01;
        end
        if (qtick_i && qleft_reg <= 6'h01) begin
          state_next = sru_pkg::SRU_DONE;
        end
      end
      sru_pkg::SRU_DONE: state_next = sru_pkg::SRU_IDLE;
      default: state_next = sru_pkg::SRU_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= sru_pkg::SRU_IDLE;
      work_reg <= '0;
      instr_reg <= sru_pkg::RESET_WORD;
      places_reg <= 5'h00;
      qleft_reg <= 6'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      work_reg <= work_next;
      places_reg <= places_next;
      qleft_reg <= qleft_next;
      if (state_reg == sru_pkg::SRU_IDLE && start_i) begin
        instr_reg <= instr_i;
      end
      busy_reg <= (state_next == sru_pkg::SRU_RUN);
      done_reg <= (state_next == sru_pkg::SRU_DONE);
    end
  end

  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign regs_o = work_reg;
endmodule

// ### dv/sru_monitor.sv
// port assertions for the shift unit
`timescale 1ns/1ps
module sru_monitor (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [15:0] instr_i,
  input wire sru_pkg::sru_regs_t regs_i,
  input wire logic qtick_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire sru_pkg::sru_regs_t regs_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence take_s; start_i && !busy_o && !done_o && $past(resetn_i, 3); endsequence
  sequence finish_s; done_o && !busy_o; endsequence
  take_busy_a: assert property (take_s |=> busy_o) else $error("start not taken");
  done_bound_a: assert property (take_s |=> busy_o [*4] ##[1:80] finish_s)
    else $error("done missing or early");
  done_pulse_a: assert property (done_o |=> !done_o) else $error("done too long");
  busy_end_a: assert property ($fell(busy_o) |-> done_o)
    else $error("busy ends without done");
  done_tick_a: assert property ($rose(done_o) |-> $past(qtick_i))
    else $error("done without tick");
  done_idle_a: assert property (done_o |-> !busy_o) else $error("done while busy");
  idle_hold_a: assert property (!busy_o && !start_i |=> $stable(regs_o))
    else $error("regs move while idle");
  busy_cause_a: assert property ($rose(busy_o) |-> $past(start_i))
    else $error("busy without start");
endmodule
bind sru_shift_unit sru_monitor i_mon (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
  .start_i(start_i), .instr_i(instr_i), .regs_i(regs_i), .qtick_i(qtick_i),
  .busy_o(busy_o), .done_o(done_o), .regs_o(regs_o));

// ### dv/sru_seq_model.sv
// quarter tick source in place of the cycle sequencer
`timescale 1ns/1ps
module sru_seq_model (
  input wire logic sys_clk_i,
  input wire logic busy_i,
  input wire logic slow_i,
  output logic qtick_o
);
  logic phase_reg = 1'b0;
  always_ff @(posedge sys_clk_i) begin
    phase_reg <= ~phase_reg;
  end
  assign qtick_o = busy_i && (!slow_i || phase_reg);
endmodule

// ### dv/tb_top.sv
// self-checking bench for the shift unit
`timescale 1ns/1ps
module tb_top;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic start_i = 1'b0;
  logic slow = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  sru_pkg::sru_regs_t regs_i = '0;
  logic qtick_i, busy_o, done_o;
  sru_pkg::sru_regs_t regs_o;
  int failures = 0;
  int comparisons = 0;
  logic [15:0] ops [13] = '{16'h1350, 16'h13A8, 16'h1328, 16'h11D0, 16'h1150, 16'h1128,
    16'h11A8, 16'h1228, 16'h1340, 16'h1B80, 16'h1B00, 16'h1980, 16'h1900};
  always #25 sys_clk_i = ~sys_clk_i;
  sru_shift_unit i_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .start_i(start_i),
    .instr_i(instr_i), .regs_i(regs_i), .qtick_i(qtick_i), .busy_o(busy_o),
    .done_o(done_o), .regs_o(regs_o));
  sru_seq_model i_seq (.sys_clk_i(sys_clk_i), .busy_i(busy_o), .slow_i(slow), .qtick_o(qtick_i));
  function automatic sru_pkg::sru_regs_t model(input logic [15:0] ins,
    input sru_pkg::sru_regs_t r);
    logic l;
    logic [15:0] a, x;
    int n;
    {l, a, x} = r;
    n = ins[11] ? ins[3:0] + 1 : ins[2:0] + 1;
    for (int i = 0; i < n; i++) begin
      case (ins[11] ? ins & 16'hFFF0 : ins & 16'hFFF8)
        16'h1350: {l, a} = {a, 1'b0};
        16'h13A8: {x, l} = {1'b0, x};
        16'h1328: {l, x} = {x, 1'b0};
        16'h11D0: {a, l} = {l, a};
        16'h1150: {l, a} = {a, l};
        16'h1128: {l, x} = {x, l};
        16'h11A8: {x, l} = {l, x};
        16'h1228: if (x[15] != x[14]) l = 1'b1; else x = {x[15], x[13:0], 1'b0};
        16'h1340: l = a[15];
        16'h1B80: {a, x, l} = {1'b0, a, x};
        16'h1B00: {l, a, x} = {a, x, 1'b0};
        16'h1980: {a, x, l} = {l, a, x};
        16'h1900: {l, a, x} = {a, x, l};
        default: ;
      endcase
    end
    if (ins[15:3] == 13'h0245 && x[15] != x[14]) l = 1'b1;
    return {l, a, x};
  endfunction
  task automatic check_regs(input sru_pkg::sru_regs_t exp, input sru_pkg::sru_regs_t got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected regs_o exp %h got %h", exp, got);
    end
  endtask
  task automatic check_cycles(input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      failures++;
      $display("unexpected latency exp %0d got %0d", exp, got);
    end
  endtask
  task automatic check_flag(input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected flag exp %b got %b", exp, got);
    end
  endtask
  task automatic run_op(input logic [15:0] ins, input sru_pkg::sru_regs_t r);
    int t;
    int exp_t;
    t = 0;
    exp_t = ins == 16'h1340 ? 4 : (ins[11] ? 5 + 2 * ins[3:0] : 4 + ins[2:0]);
    start_i = 1'b1;
    instr_i = ins;
    regs_i = r;
    @(posedge sys_clk_i);
    #2 start_i = 1'b0;
    check_flag(1'b1, busy_o);
    while (done_o !== 1'b1 && t < 100) begin
      @(posedge sys_clk_i);
      #2 t++;
    end
    check_flag(1'b1, done_o);
    check_regs(model(ins, r), regs_o);
    if (!slow) check_cycles(exp_t, t);
    @(posedge sys_clk_i);
    #2;
    check_flag(1'b0, done_o);
  endtask
  task automatic test_ops(input logic [3:0] k);
    logic [15:0] ins;
    sru_pkg::sru_regs_t r;
    r = {k[0], 16'h9A5C, 16'h3C81};
    foreach (ops[i]) begin
      ins = ops[i] == 16'h1340 ? ops[i] :
        ops[i] | (ops[i][11] ? {12'h000, k} : {13'h0000, k[2:0]});
      run_op(ins, r);
    end
    run_op({13'h0200, k[2:0]}, r); // unknown code kept
    $display("test ops done");
  endtask
  task automatic test_align;
    run_op(16'h122F, {1'b0, 16'h1234, 16'h0300}); // early stop
    run_op(16'h1229, {1'b0, 16'h1234, 16'h0001}); // link kept
    run_op(16'h122F, {1'b0, 16'h1234, 16'h8000}); // no shift
    $display("test align done");
  endtask
  task automatic test_slow;
    slow = 1'b1;
    run_op(16'h190F, {1'b1, 16'h8001, 16'h7FFE}); // slow ticks
    run_op(16'h1357, {1'b1, 16'hF00F, 16'h0000}); // slow ticks
    slow = 1'b0;
    $display("test slow done");
  endtask
  task automatic stop_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge sys_clk_i);
    #2 resetn_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #2;
    test_ops(4'h0);
    test_ops(4'hF);
    test_align();
    test_slow();
    stop_test();
  end
endmodule
